// File: hw/sarcrp_pkg.sv
package sarcrp_pkg;

    // result width and channel count
    localparam int RES_BITS = 15;
    localparam int NUM_CHANNELS = 4;

    // pin synchroniser vector layout
    localparam int PIN_W = 3;
    localparam int PIN_CONVERT = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_EDGE_RATE = 2;

    // index of the trial bit handled by the first conversion step
    localparam logic [3:0] FIRST_BIT = 4'hE;
    localparam logic [3:0] LAST_BIT = 4'h0;

    // reset values
    localparam logic [PIN_W-1:0] PIN_RST = 3'h7;
    localparam logic [RES_BITS-1:0] WORD_RST = 15'h0000;

    // timing: shortest conversion cycle at the top sample rate
    localparam int CLK_PERIOD_NS = 8;
    localparam int CYCLE_MIN_NS = 200;
    localparam int CYCLE_MIN_CLKS =
        (CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_ACQ = 3'b001,
        ST_CONV = 3'b010,
        ST_LOAD = 3'b100
    } sarcrp_state_e;

endpackage

// File: hw/sarcrp_channel.sv
`timescale 1ns/10ps
`default_nettype none
module sarcrp_channel
    import sarcrp_pkg::*;
#(
    parameter int W = RES_BITS
)
(
    input wire logic clock_i, // core clock
    input wire logic rst_b_i, // sync reset, active low
    input wire logic clk_en_i, // freezes state while low
    input wire logic begin_i, // convert edge seen: load and restart
    input wire logic step_en_i, // one trial step this cycle
    input wire logic [3:0] step_bit_i, // trial bit under test
    input wire logic finish_i, // search done: latch result
    input wire logic shift_i, // serial shift edge
    input wire logic comparator_i, // high: sample at or above trial
    output logic [W-1:0] capacitive_trial_dac_o, // trial dac code
    output logic serial_o // serial result, msb first
);

    logic [W-1:0] trial_q, trial_d;
    logic [W-1:0] result_q, result_d;
    logic [W-1:0] shift_q, shift_d;

    always_comb
    begin
        trial_d = trial_q;
        result_d = result_q;
        shift_d = shift_q;
        if (begin_i)
        begin
            trial_d = {1'b1, {(W-1){1'b0}}};
            shift_d = result_q;
        end
        else
        begin
            if (step_en_i)
            begin
                // drop the bit if the held sample is below the trial
                if (!comparator_i)
                    trial_d[step_bit_i] = 1'b0;
                if (step_bit_i != LAST_BIT)
                    trial_d[step_bit_i - 4'h1] = 1'b1;
            end
            if (shift_i)
                shift_d = {shift_q[W-2:0], 1'b0};
        end
        // offset binary to two's complement; no clamping, any code passes
        if (finish_i)
            result_d = {~trial_q[W-1], trial_q[W-2:0]};
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
        begin
            trial_q <= WORD_RST;
            result_q <= WORD_RST;
            shift_q <= WORD_RST;
        end
        else if (clk_en_i)
        begin
            trial_q <= trial_d;
            result_q <= result_d;
            shift_q <= shift_d;
        end
    end

    assign capacitive_trial_dac_o = trial_q;
    assign serial_o = shift_q[W-1];

    property p_result_fmt;
        @(posedge clock_i) disable iff (!rst_b_i)
        (clk_en_i && finish_i) |=>
            result_q == {~$past(trial_q[W-1]), $past(trial_q[W-2:0])};
    endproperty
    a_result_fmt: assert property (p_result_fmt)
        else $error("result not formatted from final trial code");

    property p_load_prev;
        @(posedge clock_i) disable iff (!rst_b_i)
        (clk_en_i && begin_i) |=> serial_o == $past(result_q[W-1]);
    endproperty
    a_load_prev: assert property (p_load_prev)
        else $error("previous result msb not presented after convert");

    property p_shift_hold;
        @(posedge clock_i) disable iff (!rst_b_i)
        !(clk_en_i && (shift_i || begin_i)) |=> $stable(shift_q);
    endproperty
    a_shift_hold: assert property (p_shift_hold)
        else $error("serial data moved without a shift edge");

    // a shift moves the word up by one place and fills with zero
    property p_shift_step;
        @(posedge clock_i) disable iff (!rst_b_i)
        (clk_en_i && shift_i && !begin_i) |=>
            shift_q == {$past(shift_q[W-2:0]), 1'b0};
    endproperty
    a_shift_step: assert property (p_shift_step)
        else $error("serial data did not advance one bit on a shift edge");

endmodule
`default_nettype wire

// File: hw/sarcrp_top.sv
// Overview of operation
// - Alternate input acquisition with conversion of the held sample.
// - A falling edge on the active-low convert strobe starts conversion.
// - Conversion steps a 15-bit trial dac through a binary search.
// - The finished 15-bit code is loaded into the output path.
// - Results are two's complement, full span in 2^15 levels.
// - Fully differential input spans every code, 0x4000 up to 0x3FFF.
// - Pseudo-differential bipolar input spans 0x6000 up to 0x1FFF.
// - Pseudo-differential unipolar input spans 0x0000 up to 0x3FFF.
// - No input mode setting; always the plain difference is converted.
// - One cycle latency: data after a convert edge is the previous result.
// - Acquisition resumes once conversion ends; strobe going low starts conversion and readout.
// - Single rate: msb first, shifted on serial clock falling edges.
// - Edge-rate select high: one bit shifted on every serial clock edge.
// - Echoed clock output follows the serial clock with a small delay.
`timescale 1ns/10ps
`default_nettype none
module sarcrp_top
    import sarcrp_pkg::*;
#(
    parameter int CHANNELS = NUM_CHANNELS,
    parameter int W = RES_BITS
)
(
    input wire logic clock_i, // core clock, 125 MHz
    input wire logic rst_b_i, // sync reset, active low
    input wire logic clk_en_i, // freezes state while low
    input wire logic convert_strobe_n_i, // convert pin, active low
    input wire logic serial_clock_i, // host serial clock pin
    input wire logic edge_rate_select_i, // high: shift on both edges
    input wire logic [CHANNELS-1:0] comparator_i, // per-channel compare
    output logic acquire_o, // sample switch closed
    output logic [CHANNELS*W-1:0] capacitive_trial_dac_o, // trial codes
    output logic [CHANNELS-1:0] channel_serial_out_o, // serial data
    output logic echoed_clock_out_o // delayed serial clock
);

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] sync1_q, sync1_d;
    logic [PIN_W-1:0] sync2_q, sync2_d;
    logic conv_prev_q, conv_prev_d;
    logic sclk_prev_q, sclk_prev_d;
    logic conv_fall, sclk_fall, sclk_rise, shift_pulse, begin_pulse;
    sarcrp_state_e state_q, state_d;
    logic [3:0] bit_q, bit_d;

    assign pin_raw = {edge_rate_select_i, serial_clock_i,
                      convert_strobe_n_i};

    // pins are asynchronous to the core clock; only the second stage is used
    always_comb
    begin
        sync1_d = pin_raw;
        sync2_d = sync1_q;
        conv_prev_d = sync2_q[PIN_CONVERT];
        sclk_prev_d = sync2_q[PIN_SCLK];
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
        begin
            sync1_q <= PIN_RST;
            sync2_q <= PIN_RST;
            conv_prev_q <= 1'b1;
            sclk_prev_q <= 1'b1;
        end
        else if (clk_en_i)
        begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            conv_prev_q <= conv_prev_d;
            sclk_prev_q <= sclk_prev_d;
        end
    end

    assign conv_fall = conv_prev_q && !sync2_q[PIN_CONVERT];
    assign sclk_fall = sclk_prev_q && !sync2_q[PIN_SCLK];
    assign sclk_rise = !sclk_prev_q && sync2_q[PIN_SCLK];
    // edge rate pin is a strap in practice; sampled live anyway
    assign shift_pulse = sclk_fall ||
        (sync2_q[PIN_EDGE_RATE] && sclk_rise);
    // a convert edge during conversion is ignored; the host must space them
    assign begin_pulse = conv_fall && (state_q == ST_ACQ);

    always_comb
    begin
        state_d = state_q;
        bit_d = bit_q;
        case (state_q)
            ST_ACQ:
            begin
                if (conv_fall)
                begin
                    state_d = ST_CONV;
                    bit_d = FIRST_BIT;
                end
            end
            ST_CONV:
            begin
                if (bit_q == LAST_BIT)
                    state_d = ST_LOAD;
                else
                    bit_d = bit_q - 4'h1;
            end
            ST_LOAD:
            begin
                state_d = ST_ACQ;
            end
            default:
            begin
                state_d = ST_ACQ;
                bit_d = FIRST_BIT;
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
        begin
            state_q <= ST_ACQ;
            bit_q <= FIRST_BIT;
        end
        else if (clk_en_i)
        begin
            state_q <= state_d;
            bit_q <= bit_d;
        end
    end

    assign acquire_o = (state_q == ST_ACQ);
    assign echoed_clock_out_o = sclk_prev_q;

    // every channel shares one start and one shift; no per-mode handling
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : g_chan
            sarcrp_channel #(
                .W(W)
            ) u_chan (
                .clock_i(clock_i),
                .rst_b_i(rst_b_i),
                .clk_en_i(clk_en_i),
                .begin_i(begin_pulse),
                .step_en_i(state_q == ST_CONV),
                .step_bit_i(bit_q),
                .finish_i(state_q == ST_LOAD),
                .shift_i(shift_pulse),
                .comparator_i(comparator_i[ch]),
                .capacitive_trial_dac_o(capacitive_trial_dac_o[ch*W +: W]),
                .serial_o(channel_serial_out_o[ch])
            );
        end
    endgenerate

    sequence s_conv_fall;
        clk_en_i && conv_fall && (state_q == ST_ACQ);
    endsequence

    sequence s_enter_conv;
        (state_q == ST_CONV) && (bit_q == FIRST_BIT);
    endsequence

    property p_start;
        @(posedge clock_i) disable iff (!rst_b_i)
        s_conv_fall |=> s_enter_conv;
    endproperty
    a_start: assert property (p_start)
        else $error("convert edge did not start conversion");

    property p_step;
        @(posedge clock_i) disable iff (!rst_b_i)
        (clk_en_i && state_q == ST_CONV && bit_q != LAST_BIT) |=>
            (state_q == ST_CONV) && (bit_q == $past(bit_q) - 4'h1);
    endproperty
    a_step: assert property (p_step)
        else $error("trial step sequence broken");

    property p_finish;
        @(posedge clock_i) disable iff (!rst_b_i)
        (clk_en_i && state_q == ST_CONV && bit_q == LAST_BIT) |=>
            (state_q == ST_LOAD) ##1 (state_q == ST_ACQ || !$past(clk_en_i));
    endproperty
    a_finish: assert property (p_finish)
        else $error("conversion did not end in load then acquire");

    property p_acquire;
        @(posedge clock_i) disable iff (!rst_b_i)
        s_conv_fall |=> !acquire_o;
    endproperty
    a_acquire: assert property (p_acquire)
        else $error("sample switch still closed during conversion");

    property p_echo;
        @(posedge clock_i) disable iff (!rst_b_i)
        clk_en_i |=> echoed_clock_out_o == $past(sync2_q[PIN_SCLK]);
    endproperty
    a_echo: assert property (p_echo)
        else $error("echoed clock does not follow serial clock");

    property p_both_edges;
        @(posedge clock_i) disable iff (!rst_b_i)
        (sync2_q[PIN_EDGE_RATE] && (sclk_rise || sclk_fall)) |->
            shift_pulse;
    endproperty
    a_both_edges: assert property (p_both_edges)
        else $error("double rate edge did not shift");

    property p_single_edge;
        @(posedge clock_i) disable iff (!rst_b_i)
        (!sync2_q[PIN_EDGE_RATE] && sclk_rise) |-> !shift_pulse;
    endproperty
    a_single_edge: assert property (p_single_edge)
        else $error("single rate shifted on a rising edge");

endmodule
`default_nettype wire

// File: bench/sarcrp_host.sv
`timescale 1ns/10ps
`default_nettype none
module sarcrp_host
    import sarcrp_pkg::*;
(
    input wire logic clock_i, // core clock
    input wire logic [NUM_CHANNELS-1:0] data_i, // serial data
    input wire logic echo_i, // echoed serial clock
    input wire logic acq_i, // device acquire flag
    output logic convert_strobe_n_o, // convert strobe
    output logic serial_clock_o, // serial clock, idles high
    output logic edge_rate_select_o // high: both edges
);
    initial
    begin
        convert_strobe_n_o = 1'b1;
        serial_clock_o = 1'b1;
        edge_rate_select_o = 1'b0;
    end

    // half of an 80 ns serial period; echo must have caught up by then
    task automatic tick(inout logic ok);
        serial_clock_o = ~serial_clock_o;
        repeat (5) @(negedge clock_i);
        ok &= (echo_i === serial_clock_o);
    endtask

    task automatic frame(input logic ddr,
        output logic [NUM_CHANNELS*RES_BITS-1:0] w,
        output logic e_ok, output logic acq_mid);
        e_ok = 1'b1;
        w = '0;
        edge_rate_select_o = ddr;
        convert_strobe_n_o = 1'b0;
        repeat (6) @(negedge clock_i);
        acq_mid = acq_i;
        for (int n = 0; n < 16; n++)
        begin
            if (n < RES_BITS)
                for (int c = 0; c < NUM_CHANNELS; c++)
                    w[c*RES_BITS+RES_BITS-1-n] = data_i[c];
            tick(e_ok);
            if (!ddr)
                tick(e_ok);
        end
        convert_strobe_n_o = 1'b1;
        // clock stands still; next fall only after readout
        repeat (30) @(negedge clock_i);
    endtask
endmodule
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import sarcrp_pkg::*;
    localparam int CW = NUM_CHANNELS*RES_BITS;
    logic clock_i, rst_b_i, conv_n, sclk, ers, acq, echo;
    logic [NUM_CHANNELS-1:0] cmp, sdo;
    logic [CW-1:0] dac, codes, prev;
    int fails = 0;
    int n_checks = 0;
    logic [RES_BITS-1:0] tbl [5] =
        '{15'h4000, 15'h3FFF, 15'h6000, 15'h1FFF, 15'h0000};

    // ideal comparator: held sample is the offset binary form of the code
    for (genvar g = 0; g < NUM_CHANNELS; g++)
    begin : g_cmp
        assign cmp[g] = dac[g*RES_BITS +: RES_BITS] <=
            {~codes[g*RES_BITS+RES_BITS-1], codes[g*RES_BITS +: RES_BITS-1]};
    end

    sarcrp_top u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1),
        .convert_strobe_n_i(conv_n), .serial_clock_i(sclk),
        .edge_rate_select_i(ers), .comparator_i(cmp), .acquire_o(acq),
        .capacitive_trial_dac_o(dac), .channel_serial_out_o(sdo),
        .echoed_clock_out_o(echo));

    sarcrp_host u_host (.clock_i(clock_i), .data_i(sdo), .echo_i(echo),
        .acq_i(acq), .convert_strobe_n_o(conv_n), .serial_clock_o(sclk),
        .edge_rate_select_o(ers));

    task automatic check(input string name, input logic [CW-1:0] seen,
        input logic [CW-1:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (fails == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    function automatic logic [CW-1:0] code_set(input int i);
        logic [CW-1:0] r;
        for (int c = 0; c < NUM_CHANNELS; c++)
            r[c*RES_BITS +: RES_BITS] = tbl[(i+c)%5];
        return r;
    endfunction

    // codes given now are converted by this frame, read by the next
    task automatic run_frame(input logic ddr, input logic [CW-1:0] nxt);
        logic [CW-1:0] w;
        logic e_ok, mid;
        codes = nxt;
        u_host.frame(ddr, w, e_ok, mid);
        check("word", w, prev);
        check("echo", CW'(e_ok), CW'(1'b1));
        check("acq_conv", CW'(mid), '0);
        check("acq_idle", CW'(acq), CW'(1'b1));
        prev = nxt;
    endtask

    task automatic t_reset();
        rst_b_i = 1'b0;
        repeat (10) @(negedge clock_i);
        check("rst_acq", CW'(acq), CW'(1'b1));
        check("rst_dac", dac, '0);
        check("rst_sdo", CW'(sdo), '0);
        check("rst_echo", CW'(echo), CW'(1'b1));
        rst_b_i = 1'b1;
        repeat (3) @(negedge clock_i);
    endtask

    task automatic t_latency();
        prev = '0;
        run_frame(1'b0, code_set(0));
    endtask

    task automatic t_ranges();
        for (int i = 1; i <= 5; i++)
            run_frame(1'b0, code_set(i));
    endtask

    task automatic t_ddr();
        for (int i = 2; i <= 6; i++)
            run_frame(1'b1, code_set(i));
        run_frame(1'b0, code_set(0));
    endtask

    initial
    begin
        clock_i = 1'b0;
        forever
            #4 clock_i = ~clock_i;
    end

    initial
    begin
        rst_b_i = 1'b0;
        codes = '0;
        prev = '0;
        t_reset();
        t_latency();
        t_ranges();
        t_ddr();
        print_verdict();
    end

    initial
    begin
        repeat (20000) @(posedge clock_i);
        fails++;
        print_verdict();
    end
endmodule
`default_nettype wire
